// file: core/fbo_ctrl.sv
// flash block select, wait/overlay control and programming mode decode
//
// Contract
// RULE_01 - eight small block select bits, set selects
// RULE_02 - small select clears on reset, standby, no vpp
// RULE_03 - flash-disabled mode: writes ignored, reads all ones
// RULE_04 - wait/overlay loads 08 on reset, hardware standby
// RULE_05 - all wait/overlay bits writable, fields forwarded out
// RULE_06 - bit 4 plain storage, resets to zero
// RULE_07 - single overlay bit steers window to ram
// RULE_08 - single overlay bit blocks program and erase
// RULE_09 - both bits: overlay starts after interrupt with vpp
// RULE_10 - overlay encoding selects the ram and flash windows
// RULE_11 - large select bits map to large ranges
// RULE_12 - small select bits map to small ranges
// RULE_13 - boot or user programming from pins and vpp
// RULE_14 - mode report shows mode pins as normal
// RULE_15 - software clears overlay bits before programming
// RULE_16 - op control bits: program, erase, verifies
// RULE_17 - flash registers reachable only with vpp present
// RULE_18 - overlay redirects reads and writes keeping offset
module fbo_ctrl
   import fbo_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [APB_AW-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // pins
   input wire logic program_voltage_pin_in,
   input wire logic mode_pin_hi_hv_in,
   input wire logic mode_pin_hi_in,
   input wire logic mode_pin_lo_in,
   // system state from same clock
   input wire logic sw_standby_in,
   input wire logic hw_standby_in,
   input wire logic irq_in,
   // cpu memory address path
   input wire logic [15:0] cpu_addr_in,
   output logic [15:0] mem_addr_out,
   output logic ram_sel_out,
   output logic blk_selected_out,
   // forwarded controls
   output logic periph_clock_double_out,
   output logic [1:0] wait_mode_sel_out,
   output logic [1:0] wait_count_out,
   output logic program_mode_out,
   output logic erase_mode_out,
   output logic program_check_mode_out,
   output logic erase_check_mode_out,
   output logic boot_mode_out,
   output logic user_prog_mode_out
);
   // pin synchronisers
   logic [3:0] pin_raw;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic vpp_ok;
   logic md_hv;
   logic md_hi;
   logic md_lo;

   assign pin_raw = {program_voltage_pin_in, mode_pin_hi_hv_in,
      mode_pin_hi_in, mode_pin_lo_in};

   // logic reads only the second flop of each pair
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
         end else begin
            sync1_q[i] <= pin_raw[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   assign vpp_ok = sync2_q[3];
   assign md_hv = sync2_q[2];
   // a 12 V level on the high mode pin also reads as logic high
   assign md_hi = sync2_q[1] | md_hv;
   assign md_lo = sync2_q[0];

   // operating mode from mode pins
   logic mode1;
   logic mode2;
   assign mode1 = !md_hi && md_lo;
   assign mode2 = md_hi && !md_lo;
   // mode 3 is either remaining code (both pins low or both high), with flash enabled

   // boot mode caught once the synchronisers hold the pin levels
   logic [1:0] strap_wait_q;
   logic strap_done_q;
   logic boot_q;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strap_wait_q <= 2'b00;
         strap_done_q <= 1'b0;
         boot_q <= 1'b0;
      end else begin
         // synchronisers restart from zero, so wait out their depth
         strap_wait_q <= {strap_wait_q[0], 1'b1};
         if (strap_wait_q[1] && !strap_done_q) begin
            strap_done_q <= 1'b1;
            boot_q <= vpp_ok && md_hv; // [RULE_13]
         end
      end
   end

   // user programming when vpp present and mode pin high [RULE_13]
   logic user_prog_d;
   assign user_prog_d = !boot_q && vpp_ok && md_hi && !md_hv;

   // apb decode
   logic [15:0] idx;
   logic setup;
   logic wr_en;
   logic hit_fop;
   logic hit_lbs;
   logic hit_sbs;
   logic hit_woc;
   logic hit_mdr;
   logic flash_reg;
   logic flash_ext;
   logic unmapped;
   logic flash_locked;

   assign idx = paddr_in[17:2];
   assign setup = psel_in && !penable_in;
   assign hit_fop = (idx == FLASH_OP_CTRL_IDX);
   assign hit_lbs = (idx == LARGE_BLK_SEL_IDX);
   assign hit_sbs = (idx == SMALL_BLK_SEL_IDX);
   assign hit_woc = (idx == WAIT_OVL_CTRL_IDX);
   assign hit_mdr = (idx == MODE_REPORT_IDX);
   assign flash_reg = hit_fop || hit_lbs || hit_sbs;
   // without vpp, mode 2 treats flash registers as external space
   assign flash_ext = flash_reg && !vpp_ok && mode2; // [RULE_17]
   assign unmapped = !(flash_reg || hit_woc || hit_mdr)
      || (paddr_in[1:0] != 2'b00) || flash_ext;
   // flash registers frozen in mode 1 or without vpp
   assign flash_locked = mode1 || !vpp_ok; // [RULE_03] [RULE_17]
   assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0]
      && !unmapped;

   // zero wait states: every access ends in its first access cycle
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && unmapped;

   // wait and overlay control
   logic [7:0] woc_q;
   logic standby;
   // either standby mode clears the flash registers
   assign standby = sw_standby_in || hw_standby_in;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         woc_q <= WAIT_OVL_RST; // [RULE_04]
      end else if (hw_standby_in) begin
         woc_q <= WAIT_OVL_RST; // [RULE_04]
      end else if (wr_en && hit_woc) begin
         // software standby leaves the register as is [RULE_04]
         woc_q <= pwdata_in[7:0]; // [RULE_05] [RULE_06]
      end
   end

   assign periph_clock_double_out = woc_q[WOC_CLK_DBL]; // [RULE_05]
   assign wait_mode_sel_out = {woc_q[WOC_WMS_HI], woc_q[WOC_WMS_LO]};
   assign wait_count_out = {woc_q[WOC_WC_HI], woc_q[WOC_WC_LO]};

   // overlay state
   fbo_ovl_t ovl_sel;
   logic single_ovl;
   logic irq_seen_q;
   logic ovl_active;

   assign ovl_sel = fbo_ovl_t'({woc_q[WOC_OVL_HI], woc_q[WOC_OVL_LO]});
   assign single_ovl = (ovl_sel == FBO_OVL_LO) || (ovl_sel == FBO_OVL_HI);
   // interrupt latch drops when software leaves the both-bits code

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_seen_q <= 1'b0;
      end else if (ovl_sel != FBO_OVL_IRQ) begin
         irq_seen_q <= 1'b0;
      end else if (irq_in && vpp_ok) begin
         irq_seen_q <= 1'b1; // [RULE_09]
      end
   end

   // both bits set keep flash until the interrupt arrives [RULE_09]
   assign ovl_active = single_ovl || irq_seen_q; // [RULE_07]

   // flash operation control
   logic [3:0] fop_q;
   logic [3:0] fop_wr;

   assign fop_wr = pwdata_in[3:0];

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fop_q <= 4'h0;
      end else if (standby || !vpp_ok) begin
         fop_q <= 4'h0;
      end else if (wr_en && hit_fop && !flash_locked) begin
         fop_q <= fop_wr; // [RULE_16]
      end
   end

   // emulation protect blocks program and erase only [RULE_08]
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         program_mode_out <= 1'b0;
         erase_mode_out <= 1'b0;
         program_check_mode_out <= 1'b0;
         erase_check_mode_out <= 1'b0;
      end else begin
         program_mode_out <= fop_q[FOP_PROGRAM] && !single_ovl; // [RULE_08]
         erase_mode_out <= fop_q[FOP_ERASE] && !single_ovl; // [RULE_08]
         program_check_mode_out <= fop_q[FOP_PROG_CHECK]; // [RULE_16]
         erase_check_mode_out <= fop_q[FOP_ERASE_CHECK]; // [RULE_16]
      end
   end

   // large block select
   logic [7:0] lbs_q;
   logic [7:0] lbs_mask;
   always_comb begin
      lbs_mask = ALL_ONES;
      if (mode2) begin
         lbs_mask[LB_MODE2_LOCK] = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lbs_q <= BLK_SEL_RST;
      end else if (standby || !vpp_ok) begin
         lbs_q <= BLK_SEL_RST;
      end else if (wr_en && hit_lbs && !flash_locked) begin
         // top large block bit cannot change in mode 2
         lbs_q <= (pwdata_in[7:0] & lbs_mask) | (lbs_q & ~lbs_mask);
      end
   end

   // small block select
   logic [7:0] sbs_q;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sbs_q <= BLK_SEL_RST; // [RULE_02]
      end else if (standby || !vpp_ok) begin
         sbs_q <= BLK_SEL_RST; // [RULE_02]
      end else if (wr_en && hit_sbs && !flash_locked) begin
         sbs_q <= pwdata_in[7:0]; // [RULE_01] [RULE_03]
      end
   end

   // read data, latched in the setup cycle
   logic [7:0] rd_byte;
   logic [7:0] fop_view;
   logic [7:0] mdr_view;

   always_comb begin
      fop_view = 8'h00;
      fop_view[FOP_VPP] = vpp_ok;
      fop_view[3:0] = fop_q;
   end
   // mode report mirrors the pins also in boot mode [RULE_14]
   assign mdr_view = {6'b000000, md_hi, md_lo};

   always_comb begin
      rd_byte = 8'h00;
      if (hit_woc) begin
         rd_byte = woc_q;
      end else if (hit_mdr) begin
         rd_byte = mdr_view; // [RULE_14]
      end else if (flash_reg && mode1) begin
         rd_byte = BLK_SEL_MODE1; // [RULE_03]
      end else if (flash_reg && flash_locked) begin
         rd_byte = ALL_ONES; // [RULE_17]
      end else if (hit_fop) begin
         rd_byte = fop_view;
      end else if (hit_lbs) begin
         rd_byte = lbs_q;
      end else if (hit_sbs) begin
         rd_byte = sbs_q; // [RULE_01]
      end
      // unmapped or external reads return zero with an error
      if (unmapped) begin
         rd_byte = 8'h00;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (setup && !pwrite_in) begin
         prdata_out <= {24'h000000, rd_byte};
      end
   end

   // address steering and block selection
   logic [15:0] map_addr;
   logic map_ram;
   logic [7:0] lb_hit;
   logic [7:0] sb_hit;

   fbo_addr_map u_map (
      .ovl_sel_in(ovl_sel),
      .ovl_active_in(ovl_active),
      .addr_in(cpu_addr_in),
      .addr_out(map_addr),
      .ram_hit_out(map_ram),
      .large_hit_out(lb_hit),
      .small_hit_out(sb_hit)
   );

   assign mem_addr_out = map_addr; // [RULE_18]
   assign ram_sel_out = map_ram; // [RULE_07]
   // an overlaid address never reaches the flash array
   assign blk_selected_out = |((lb_hit & lbs_q) | (sb_hit & sbs_q))
      && !map_ram; // [RULE_11] [RULE_12]

   // programming mode outputs
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         boot_mode_out <= 1'b0;
         user_prog_mode_out <= 1'b0;
      end else begin
         boot_mode_out <= boot_q; // [RULE_13]
         user_prog_mode_out <= user_prog_d; // [RULE_13]
      end
   end
endmodule : fbo_ctrl

// file: include/fbo_pkg.sv
// constants for the flash block select and ram overlay controller
package fbo_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] FLASH_OP_CTRL_IDX = 16'hFF80;
   localparam logic [15:0] LARGE_BLK_SEL_IDX = 16'hFF82;
   localparam logic [15:0] SMALL_BLK_SEL_IDX = 16'hFF83;
   localparam logic [15:0] WAIT_OVL_CTRL_IDX = 16'hFFC2;
   localparam logic [15:0] MODE_REPORT_IDX = 16'hFFC5;
   localparam int APB_AW = 18;

   // reset values and fixed read patterns
   localparam logic [7:0] BLK_SEL_RST = 8'h00;
   localparam logic [7:0] BLK_SEL_MODE1 = 8'hFF;
   localparam logic [7:0] WAIT_OVL_RST = 8'h08;
   localparam logic [7:0] ALL_ONES = 8'hFF;

   // flash operation control fields
   localparam int FOP_PROGRAM = 0;
   localparam int FOP_ERASE = 1;
   localparam int FOP_PROG_CHECK = 2;
   localparam int FOP_ERASE_CHECK = 3;
   localparam int FOP_VPP = 7;

   // wait and overlay control fields, and the mode 2 large block lock bit
   localparam int WOC_OVL_HI = 7;
   localparam int WOC_OVL_LO = 6;
   localparam int WOC_CLK_DBL = 5;
   localparam int WOC_RSVD = 4;
   localparam int WOC_WMS_HI = 3;
   localparam int WOC_WMS_LO = 2;
   localparam int WOC_WC_HI = 1;
   localparam int WOC_WC_LO = 0;
   localparam int LB_MODE2_LOCK = 7;

   // overlay windows: flash base, ram base, last offset
   localparam logic [15:0] OVL01_FLASH = 16'h0080;
   localparam logic [15:0] OVL01_RAM = 16'hF880;
   localparam logic [15:0] OVL01_LAST = 16'h007F;
   localparam logic [15:0] OVL10_FLASH = 16'h0080;
   localparam logic [15:0] OVL10_RAM = 16'hF880;
   localparam logic [15:0] OVL10_LAST = 16'h00FF;
   localparam logic [15:0] OVL11_FLASH = 16'h0000;
   localparam logic [15:0] OVL11_RAM = 16'hF800;
   localparam logic [15:0] OVL11_LAST = 16'h007F;

   // erase block range starts; each block ends below the next start
   localparam logic [15:0] LB_START [0:8] = '{16'h1000, 16'h2000,
      16'h4000, 16'h6000, 16'h8000, 16'hA000, 16'hC000, 16'hEF80,
      16'hF780};
   localparam logic [15:0] SB_START [0:8] = '{16'h0000, 16'h0080,
      16'h0100, 16'h0180, 16'h0200, 16'h0400, 16'h0800, 16'h0C00,
      16'h1000};

   typedef enum logic [1:0] {
      FBO_OVL_NONE = 2'b00,
      FBO_OVL_LO = 2'b01,
      FBO_OVL_HI = 2'b10,
      FBO_OVL_IRQ = 2'b11
   } fbo_ovl_t;
endpackage : fbo_pkg

// file: core/fbo_addr_map.sv
// overlay address steering and erase block lookup for one cpu address
module fbo_addr_map
   import fbo_pkg::*;
(
   // overlay control
   input wire logic [1:0] ovl_sel_in,
   input wire logic ovl_active_in,
   // address
   input wire logic [15:0] addr_in,
   // results
   output logic [15:0] addr_out,
   output logic ram_hit_out,
   output logic [7:0] large_hit_out,
   output logic [7:0] small_hit_out
);
   logic [15:0] fbase;
   logic [15:0] rbase;
   logic [15:0] last;
   logic [15:0] offs;

   always_comb begin
      unique case (ovl_sel_in)
         FBO_OVL_LO: begin
            fbase = OVL01_FLASH;
            rbase = OVL01_RAM;
            last = OVL01_LAST;
         end
         FBO_OVL_HI: begin
            fbase = OVL10_FLASH;
            rbase = OVL10_RAM;
            last = OVL10_LAST;
         end
         FBO_OVL_IRQ: begin
            fbase = OVL11_FLASH;
            rbase = OVL11_RAM;
            last = OVL11_LAST;
         end
         FBO_OVL_NONE: begin
            fbase = 16'h0000;
            rbase = 16'h0000;
            last = 16'h0000;
         end
      endcase
   end

   // window offset kept, base swapped [RULE_10] [RULE_18]
   assign offs = 16'(addr_in - fbase);
   assign ram_hit_out = ovl_active_in && (ovl_sel_in != FBO_OVL_NONE)
      && (addr_in >= fbase) && (offs <= last); // [RULE_07]
   assign addr_out = ram_hit_out ? 16'(rbase + offs) : addr_in; // [RULE_18]

   // block ranges per select bit [RULE_11] [RULE_12]
   for (genvar i = 0; i < 8; i++) begin : g_blk
      assign large_hit_out[i] = (addr_in >= LB_START[i])
         && (addr_in < LB_START[i+1]);
      assign small_hit_out[i] = (addr_in >= SB_START[i])
         && (addr_in < SB_START[i+1]);
   end
endmodule : fbo_addr_map

// file: dv/fbo_ctrl_props.sv
// port assertions for the flash block select and overlay controller
module fbo_ctrl_props
   import fbo_pkg::*;
(
   // clock, reset and bus
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [APB_AW-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   // pins and steering
   input wire logic program_voltage_pin_in,
   input wire logic hw_standby_in,
   input wire logic irq_in,
   input wire logic [15:0] cpu_addr_in,
   input wire logic [15:0] mem_addr_out,
   input wire logic ram_sel_out,
   // forwarded controls
   input wire logic periph_clock_double_out,
   input wire logic [1:0] wait_mode_sel_out,
   input wire logic [1:0] wait_count_out,
   input wire logic program_mode_out,
   input wire logic erase_mode_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] woc_q;
   logic ovl1;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_b_in);
   // mirror of the wait/overlay register built from bus writes
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         woc_q <= 8'h08;
      end else if (hw_standby_in) begin
         woc_q <= 8'h08;
      end else if (psel_in && penable_in && pwrite_in && pstrb_in[0]
            && paddr_in == {WAIT_OVL_CTRL_IDX, 2'b00}) begin
         woc_q <= pwdata_in[7:0];
      end
   end
   assign ovl1 = woc_q[7] ^ woc_q[6];
   sequence armed_s;
      (woc_q[7:6] == 2'b11 && program_voltage_pin_in) [*3] ##0 irq_in;
   endsequence
   sequence low_hit_s;
      woc_q[7:6] == 2'b11 && cpu_addr_in < 16'h0080;
   endsequence
   fwd_fields_a: assert property (
      {periph_clock_double_out, wait_mode_sel_out, wait_count_out}
         == {woc_q[5], woc_q[3:0]})
      else $error("forwarded fields wrong");
   hw_standby_a: assert property (
      hw_standby_in |=> {periph_clock_double_out, wait_mode_sel_out,
         wait_count_out} == 5'h08)
      else $error("standby load wrong");
   ovl_none_a: assert property (
      woc_q[7:6] == 2'b00 |-> !ram_sel_out && mem_addr_out == cpu_addr_in)
      else $error("steered without overlay");
   ovl_lo_a: assert property (
      woc_q[7:6] == 2'b01 && cpu_addr_in inside {[16'h0080:16'h00FF]}
         |-> ram_sel_out && mem_addr_out == cpu_addr_in + 16'hF800)
      else $error("low window not steered");
   lo_end_a: assert property (
      woc_q[7:6] == 2'b01 && cpu_addr_in inside {[16'h0100:16'h017F]}
         |-> !ram_sel_out)
      else $error("low window too wide");
   ovl_hi_a: assert property (
      woc_q[7:6] == 2'b10 && cpu_addr_in inside {[16'h0080:16'h017F]}
         |-> ram_sel_out && mem_addr_out == cpu_addr_in + 16'hF800)
      else $error("high window not steered");
   write_protect_a: assert property (
      ovl1 && $past(ovl1) |-> !program_mode_out && !erase_mode_out)
      else $error("program or erase under overlay");
   irq_overlay_a: assert property (
      armed_s ##1 low_hit_s |-> ram_sel_out
         && mem_addr_out == cpu_addr_in + 16'hF800)
      else $error("interrupt overlay missing");
endmodule : fbo_ctrl_props

// file: dv/fbo_cpu_model.sv
// cpu side model presenting memory addresses to the steering logic
module fbo_cpu_model
(
   input wire logic mclk_in,
   output logic [15:0] cpu_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cpu_addr_out = 16'hFFFF;
   // an address is launched just after a rising edge and then held
   task automatic put(input logic [15:0] a);
      @(posedge mclk_in);
      cpu_addr_out <= a;
   endtask : put
endmodule : fbo_cpu_model

// file: dv/tb_flash_block_select_ram_overlay.sv
// self-checking bench for the flash block select and overlay controller
module tb_flash_block_select_ram_overlay
   import fbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [17:0] A_OP = {FLASH_OP_CTRL_IDX, 2'b00};
   localparam logic [17:0] A_LB = {LARGE_BLK_SEL_IDX, 2'b00};
   localparam logic [17:0] A_SB = {SMALL_BLK_SEL_IDX, 2'b00};
   localparam logic [17:0] A_WO = {WAIT_OVL_CTRL_IDX, 2'b00};
   localparam logic [17:0] A_MR = {MODE_REPORT_IDX, 2'b00};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwd = '0;
   logic vpp = 1'b1;
   logic hv = 1'b0;
   logic mhi = 1'b1;
   logic mlo = 1'b1;
   logic swsb = 1'b0;
   logic hwsb = 1'b0;
   logic irq = 1'b0;
   logic [31:0] prdata;
   logic [15:0] cpu_addr, mem_addr;
   logic [1:0] wms, wc;
   logic pready, pslverr, err, ram_sel, blk_sel, ckd;
   logic pm, em, pcm, ecm, boot, upm;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   fbo_cpu_model cpu_u (.mclk_in(clk), .cpu_addr_out(cpu_addr));
   fbo_ctrl dut_u (.mclk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwd), .pstrb_in(4'hF), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .program_voltage_pin_in(vpp), .mode_pin_hi_hv_in(hv),
      .mode_pin_hi_in(mhi), .mode_pin_lo_in(mlo), .sw_standby_in(swsb),
      .hw_standby_in(hwsb), .irq_in(irq), .cpu_addr_in(cpu_addr),
      .mem_addr_out(mem_addr), .ram_sel_out(ram_sel),
      .blk_selected_out(blk_sel), .periph_clock_double_out(ckd),
      .wait_mode_sel_out(wms), .wait_count_out(wc),
      .program_mode_out(pm), .erase_mode_out(em),
      .program_check_mode_out(pcm), .erase_check_mode_out(ecm),
      .boot_mode_out(boot), .user_prog_mode_out(upm));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset(input logic [3:0] p);
      @(posedge clk);
      rst_b <= 1'b0;
      {vpp, hv, mhi, mlo} <= p;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : do_reset
   task automatic apb(input logic w, input logic [17:0] a,
         input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      logic [7:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      logic [7:0] q;
      apb(1'b0, a, 8'h00, q);
      chk({10'h000, q}, {10'h000, e});
   endtask : rd
   task automatic look(input logic [15:0] a, input logic [17:0] e);
      cpu_u.put(a);
      @(negedge clk);
      chk({ram_sel, blk_sel, mem_addr}, e);
   endtask : look
   task automatic t_regs();
      logic [7:0] pat [4] = '{8'h10, 8'h2F, 8'hAF, 8'h5A};
      rd(A_WO, 8'h08);
      rd(A_SB, 8'h00);
      foreach (pat[i]) begin
         wr(A_WO, pat[i]);
         rd(A_WO, pat[i]);
         chk({13'h0000, ckd, wms, wc}, {13'h0000, pat[i][5],
            pat[i][3:0]});
      end
      wr(A_SB, 8'hA5);
      rd(A_SB, 8'hA5);
      swsb <= 1'b1;
      @(posedge clk);
      swsb <= 1'b0;
      rd(A_WO, 8'h5A);
      rd(A_SB, 8'h00);
      hwsb <= 1'b1;
      @(posedge clk);
      hwsb <= 1'b0;
      rd(A_WO, 8'h08);
      wr(A_SB, 8'hA5);
      vpp <= 1'b0;
      repeat (4) @(posedge clk);
      rd(A_SB, 8'hFF);
      vpp <= 1'b1;
      repeat (4) @(posedge clk);
      rd(A_SB, 8'h00);
      rd(18'h00004, 8'h00);
      chk({17'h00000, err}, 18'h00001);
      $display("test regs done");
   endtask : t_regs
   task automatic blk(input logic [17:0] r, input logic [7:0] v,
         input logic [15:0] s, input logic [15:0] n);
      wr(r, v);
      look(s, {2'b01, s});
      look(n - 16'h0001, {2'b01, n - 16'h0001});
      look(n, {2'b00, n});
      wr(r, 8'h00);
   endtask : blk
   task automatic t_blocks();
      for (int i = 0; i < 8; i++) begin
         blk(A_SB, 8'h01 << i, SB_START[i], SB_START[i+1]);
         blk(A_LB, 8'h01 << i, LB_START[i], LB_START[i+1]);
      end
      $display("test blocks done");
   endtask : t_blocks
   task automatic t_overlay();
      logic [15:0] lo [1:3] = '{16'h0080, 16'h0080, 16'h0000};
      logic [15:0] hi [1:3] = '{16'h00FF, 16'h017F, 16'h007F};
      for (int c = 1; c < 4; c++) begin
         wr(A_WO, {c[1:0], 6'h08});
         if (c == 3) begin
            look(16'h0000, {2'b00, 16'h0000});
            irq <= 1'b1;
            repeat (2) @(posedge clk);
            irq <= 1'b0;
         end
         look(lo[c], {2'b10, lo[c] + 16'hF800});
         look(hi[c], {2'b10, hi[c] + 16'hF800});
         look(hi[c] + 16'h0001, {2'b00, hi[c] + 16'h0001});
      end
      $display("test overlay done");
   endtask : t_overlay
   task automatic op(input logic [7:0] d, input logic [3:0] e);
      wr(A_OP, d);
      @(posedge clk);
      @(negedge clk);
      chk({14'h0000, ecm, pcm, em, pm}, {14'h0000, e});
   endtask : op
   task automatic t_protect();
      wr(A_WO, 8'h48);
      op(8'h01, 4'h0);
      op(8'h04, 4'h4);
      wr(A_WO, 8'h88);
      op(8'h02, 4'h0);
      op(8'h08, 4'h8);
      wr(A_WO, 8'h08);
      op(8'h01, 4'h1);
      op(8'h02, 4'h2);
      op(8'h00, 4'h0);
      $display("test protect done");
   endtask : t_protect
   task automatic t_modes();
      logic [3:0] pn [4] = '{4'b1110, 4'b1111, 4'b1010, 4'b0011};
      logic [1:0] bu [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
      foreach (pn[i]) begin
         do_reset(pn[i]);
         chk({16'h0000, boot, upm}, {16'h0000, bu[i]});
         rd(A_MR, {6'h00, pn[i][1:0]});
      end
      do_reset(4'b1001);
      rd(A_SB, 8'hFF);
      wr(A_SB, 8'h00);
      rd(A_SB, 8'hFF);
      $display("test modes done");
   endtask : t_modes
   initial begin
      do_reset(4'b1011);
      chk({16'h0000, boot, upm}, 18'h00001);
      t_regs();
      t_blocks();
      t_overlay();
      t_protect();
      t_modes();
      end_of_test();
   end
endmodule : tb_flash_block_select_ram_overlay
bind fbo_ctrl fbo_ctrl_props props_u (.mclk_in(mclk_in),
   .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pstrb_in(pstrb_in), .program_voltage_pin_in(program_voltage_pin_in),
   .hw_standby_in(hw_standby_in), .irq_in(irq_in),
   .cpu_addr_in(cpu_addr_in), .mem_addr_out(mem_addr_out),
   .ram_sel_out(ram_sel_out),
   .periph_clock_double_out(periph_clock_double_out),
   .wait_mode_sel_out(wait_mode_sel_out), .wait_count_out(wait_count_out),
   .program_mode_out(program_mode_out), .erase_mode_out(erase_mode_out));
